/* hdl/virtual_processor_disable_ctrl.sv */
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
//
// Contract
// - Decode opcode, minor and pool fields exactly
// - Old control value to register before flag
// - Stop fetch on all other processors
// - Retire only after others drain
// - Cancel prefetches and table walks on others
// - Act as full barrier toward others
// - Set flag only after others stopped
// - Sleeping processor ignores interrupts until enable
// - After enable, sleeper waits as before
// - Paused processor stays stopped until enable
// - After enable, paused resumes waiting flag
// - Enable restarts others with state intact
// - State loss while disabled is undefined
// - No-op when flag already set
// - Mask interrupts without touching enable bit
// - Deferred exceptions never restart target
// - Issuing processor stays interruptible
// - External enable cannot restart disabled one
// - Enable never overrides external fetch disable
// - Act only as oldest unretired instruction
// - No-op without multithreading present
// - Unusable coprocessor raises exception instead
module virtual_processor_disable_ctrl
    import vp_disable_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic insn_valid,
    input wire logic [DATA_W-1:0] insn,
    input wire logic insn_oldest,
    input wire logic [VP_ID_W-1:0] issuer_id,
    input wire logic cop_access_ok,
    input wire logic multithread_present_flag,
    input wire logic [NUM_VP-1:0] outstanding,
    input wire logic [NUM_VP-1:0] prefetch_busy,
    input wire logic [NUM_VP-1:0] store_pending,
    input wire logic [NUM_VP-1:0] ext_fetch_enable,
    output logic insn_retire,
    output logic insn_stall,
    output logic cop_unusable,
    output logic gpr_we,
    output logic [DEST_W-1:0] gpr_waddr,
    output logic [DATA_W-1:0] gpr_wdata,
    output logic [NUM_VP-1:0] fetch_allow,
    output logic [NUM_VP-1:0] irq_block,
    output logic [NUM_VP-1:0] prefetch_kill,
    output logic [NUM_VP-1:0] barrier_req,
    output logic threads_disabled_flag
);
    // ==========================================
    // Declarations
    seq_state_e state;
    seq_state_e next_state;
    logic is_disable;
    logic is_enable;
    logic [DEST_W-1:0] dest_reg_field;
    logic [DEST_W-1:0] dest_hold;
    logic [DATA_W-1:0] thread_control_reg;
    logic [DATA_W-1:0] old_ctrl;
    logic [NUM_VP-1:0] others;
    logic [NUM_VP-1:0] hold;
    logic [NUM_VP-1:0] ext_meta;
    logic [NUM_VP-1:0] ext_sync;
    logic start;
    logic take_dis;
    logic take_en;
    logic nop_req;
    logic trap_req;
    logic drained;
    vp_ctrl_if ctl();

    vp_insn_decode u_dec (
        .insn(insn),
        .is_disable(is_disable),
        .is_enable(is_enable),
        .dest_reg_field(dest_reg_field)
    );

    vp_target_gate u_gate (
        .clk_sys(clk_sys),
        .reset(reset),
        .ctl(ctl)
    );

    assign ctl.hold = hold;
    assign thread_control_reg = {{(DATA_W-1){1'b0}}, threads_disabled_flag};

    // ==========================================
    // Request qualification
    always_comb begin
        start = insn_valid && insn_oldest && (state == ST_IDLE) &&
                !insn_retire && !cop_unusable; // Answered request is not taken twice
        trap_req = start && (is_disable || is_enable) && !cop_access_ok;
        take_dis = start && is_disable && cop_access_ok && multithread_present_flag &&
                   !threads_disabled_flag;
        take_en = start && is_enable && cop_access_ok && multithread_present_flag;
        nop_req = start && (is_disable || is_enable) && cop_access_ok && !take_dis && !take_en;
        others = ~({{(NUM_VP-1){1'b0}}, 1'b1} << issuer_id);
        drained = ((outstanding | prefetch_busy | store_pending) & others) == '0;
    end

    // Next state of the sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take_dis) begin
                    next_state = ST_DRAIN;
                end else if (take_en) begin
                    next_state = ST_ENABLE;
                end
            end
            ST_DRAIN: begin
                if (drained) begin
                    next_state = ST_WRITEBACK;
                end
            end
            ST_WRITEBACK: next_state = ST_IDLE;
            ST_ENABLE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Capture destination and old control value when a disable is accepted
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dest_hold <= 5'h00;
            old_ctrl <= THREAD_CTRL_RESET;
        end else if (take_dis) begin
            dest_hold <= dest_reg_field;
            old_ctrl <= thread_control_reg;
        end
    end

    // Hold mask on the other processors; only enable releases it
    // No copy of target state is kept; a power loss there leaves enable undefined
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hold <= '0;
        end else if (take_dis) begin
            hold <= others;
        end else if (state == ST_ENABLE) begin
            hold <= '0;
        end
    end

    // Disabled flag set after drain, cleared by enable
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            threads_disabled_flag <= THREAD_CTRL_RESET[DISABLED_BIT];
        end else if (state == ST_DRAIN && drained) begin
            threads_disabled_flag <= 1'b1;
        end else if (state == ST_ENABLE) begin
            threads_disabled_flag <= 1'b0;
        end
    end

    // External fetch enable synchroniser
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ext_meta <= '0;
            ext_sync <= '0;
        end else begin
            ext_meta <= ext_fetch_enable;
            ext_sync <= ext_meta;
        end
    end

    // Fetch permission and interrupt blocking outputs
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fetch_allow <= '0;
            irq_block <= '0;
            prefetch_kill <= '0;
            barrier_req <= '0;
        end else begin
            fetch_allow <= ext_sync & ~ctl.fetch_stop & ~hold & ~(take_dis ? others : '0);
            irq_block <= ctl.irq_mask | hold | (take_dis ? others : '0);
            prefetch_kill <= (state == ST_DRAIN) ? hold : '0;
            barrier_req <= (state == ST_DRAIN) ? hold : '0;
        end
    end

    // Retire, trap and register write-back
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            insn_retire <= 1'b0;
            insn_stall <= 1'b0;
            cop_unusable <= 1'b0;
            gpr_we <= 1'b0;
            gpr_waddr <= 5'h00;
            gpr_wdata <= THREAD_CTRL_RESET;
        end else begin
            insn_retire <= (state == ST_WRITEBACK) || (state == ST_ENABLE) || nop_req;
            insn_stall <= (next_state == ST_DRAIN) || (next_state == ST_WRITEBACK);
            cop_unusable <= trap_req;
            gpr_we <= (state == ST_WRITEBACK) && (dest_hold != 5'h00);
            gpr_waddr <= dest_hold;
            gpr_wdata <= old_ctrl;
        end
    end

    // ==========================================
    // Checks
    a_flag_after_drain: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(threads_disabled_flag) |-> $past(state) == ST_DRAIN && $past(drained))
        else $error("flag set before drain");
    a_noop_when_set: assert property (@(posedge clk_sys) disable iff (reset)
        (start && is_disable && threads_disabled_flag) |=> state == ST_IDLE)
        else $error("disable acted while flag set");
    a_issuer_free: assert property (@(posedge clk_sys) disable iff (reset)
        take_dis |=> !hold[$past(issuer_id)])
        else $error("issuer held");
    a_no_retire_drain: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_DRAIN && !drained) |=> !insn_retire)
        else $error("retired before drain");
    a_gpr_zero_dest: assert property (@(posedge clk_sys) disable iff (reset)
        gpr_we |-> gpr_waddr != 5'h00 && gpr_wdata[DISABLED_BIT] == 1'b0)
        else $error("bad write-back");
    a_ext_no_restart: assert property (@(posedge clk_sys) disable iff (reset)
        (hold != '0 && state != ST_ENABLE) |=> ##1 (fetch_allow & hold) == '0)
        else $error("held processor fetching");
    a_enable_clears: assert property (@(posedge clk_sys) disable iff (reset)
        take_en |=> ##1 !threads_disabled_flag && hold == '0)
        else $error("enable did not clear");
    a_no_mt_noop: assert property (@(posedge clk_sys) disable iff (reset)
        (start && !multithread_present_flag) |=> state == ST_IDLE && $stable(hold))
        else $error("acted without multithreading");
    a_cop_trap: assert property (@(posedge clk_sys) disable iff (reset)
        (start && is_disable && !cop_access_ok) |=> cop_unusable && state == ST_IDLE)
        else $error("no coprocessor trap");

    // ==========================================
    // Checks on holding the other processors
    a_take_holds: assert property (@(posedge clk_sys) disable iff (reset)
        take_dis |=> hold == $past(others))
        else $error("hold not applied");

    a_fetch_cut: assert property (@(posedge clk_sys) disable iff (reset)
        take_dis |=> (fetch_allow & $past(others)) == '0)
        else $error("fetch not cut at take");

    a_held_no_fetch: assert property (@(posedge clk_sys) disable iff (reset)
        (hold != '0) |=> (fetch_allow & $past(hold)) == '0)
        else $error("held processor allowed to fetch");

    a_held_irq_masked: assert property (@(posedge clk_sys) disable iff (reset)
        (hold != '0) |=> (irq_block & $past(hold)) == $past(hold))
        else $error("held processor interruptible");

    a_issuer_irq_free: assert property (@(posedge clk_sys) disable iff (reset)
        take_dis |=> !irq_block[$past(issuer_id)])
        else $error("issuer interrupts blocked");

    a_hold_stays: assert property (@(posedge clk_sys) disable iff (reset)
        (hold != '0 && state != ST_ENABLE) |=> $stable(hold))
        else $error("hold released without enable");

    a_gate_follows_hold: assert property (@(posedge clk_sys) disable iff (reset)
        ctl.fetch_stop == $past(hold) && ctl.irq_mask == $past(hold))
        else $error("gate lost the hold mask");

    // ==========================================
    // Checks on the drain and retire
    a_kill_in_drain: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_DRAIN) |=> prefetch_kill == $past(hold))
        else $error("prefetch not cancelled");

    a_barrier_in_drain: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_DRAIN) |=> barrier_req == $past(hold))
        else $error("barrier not requested");

    a_kill_idle_low: assert property (@(posedge clk_sys) disable iff (reset)
        (state != ST_DRAIN) |=> prefetch_kill == '0 && barrier_req == '0)
        else $error("cancel outside drain");

    a_stall_drain: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_DRAIN || state == ST_WRITEBACK) |-> insn_stall)
        else $error("no stall while draining");

    a_stall_idle: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_IDLE && !take_dis) |=> !insn_stall)
        else $error("stall without disable");

    a_retire_after_wb: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_WRITEBACK) |=> insn_retire && !insn_stall)
        else $error("no retire after write-back");

    a_flag_before_wb: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_WRITEBACK) |-> threads_disabled_flag)
        else $error("flag not set at write-back");

    a_wb_dest: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_WRITEBACK && dest_hold != 5'h00) |=> gpr_we && gpr_waddr == $past(dest_hold))
        else $error("old value not written");

    a_no_we_zero: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_WRITEBACK && dest_hold == 5'h00) |=> !gpr_we)
        else $error("write to register zero");

    // ==========================================
    // Checks on enable and refused requests
    a_enable_release: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_ENABLE) |=> hold == '0 && insn_retire)
        else $error("enable did not release");

    a_fetch_restored: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_ENABLE) |=> ##2 ((($past(ext_sync) & ~fetch_allow) == '0) || $past(take_dis)))
        else $error("fetch not restored");

    a_ext_gates_fetch: assert property (@(posedge clk_sys) disable iff (reset)
        (fetch_allow & ~$past(ext_sync)) == '0)
        else $error("fetch without external enable");

    a_not_oldest: assert property (@(posedge clk_sys) disable iff (reset)
        (state == ST_IDLE && !insn_oldest) |=> state == ST_IDLE && !insn_retire && !cop_unusable)
        else $error("acted while not oldest");

    a_trap_no_change: assert property (@(posedge clk_sys) disable iff (reset)
        trap_req |=> state == ST_IDLE && $stable(hold) && $stable(threads_disabled_flag))
        else $error("trap changed state");

    a_trap_no_retire: assert property (@(posedge clk_sys) disable iff (reset)
        trap_req |=> !insn_retire && !gpr_we)
        else $error("trapped instruction retired");

    a_nop_retire: assert property (@(posedge clk_sys) disable iff (reset)
        nop_req |=> insn_retire && !gpr_we && $stable(hold))
        else $error("no-op misbehaved");

    a_flag_holds: assert property (@(posedge clk_sys) disable iff (reset)
        (threads_disabled_flag && state != ST_ENABLE) |=> threads_disabled_flag)
        else $error("flag cleared without enable");
endmodule // virtual_processor_disable_ctrl

/* hdl/vp_insn_decode.sv */
`timescale 1ns/1ps
module vp_insn_decode
    import vp_disable_pkg::*;
(
    input wire logic [DATA_W-1:0] insn,
    output logic is_disable,
    output logic is_enable,
    output logic [DEST_W-1:0] dest_reg_field
);
    logic common;

    // Field match of the disable and enable encodings
    always_comb begin
        common = (insn[MAJOR_HI:MAJOR_LO] == MAJOR_GROUP_A) &&
                 (insn[RSVD_HI:RSVD_LO] == RSVD_FIELD_ZERO) &&
                 (insn[POOL_HI:POOL_LO] == MINOR_GROUP);
        is_disable = common && (insn[MINOR_HI:MINOR_LO] == DISABLE_MINOR);
        is_enable = common && (insn[MINOR_HI:MINOR_LO] == ENABLE_MINOR);
        dest_reg_field = insn[DEST_HI:DEST_LO];
    end
endmodule // vp_insn_decode

/* hdl/vp_target_gate.sv */
`timescale 1ns/1ps
module vp_target_gate
    import vp_disable_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    vp_ctrl_if.gate ctl
);
    // ==========================================
    // Registered per-target gating
    genvar g;
    generate
        for (g = 0; g < NUM_VP; g++) begin : g_vp
            // Hold stops fetch and masks interrupts, status bits untouched
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    ctl.fetch_stop[g] <= 1'b0;
                    ctl.irq_mask[g] <= 1'b0;
                end else begin
                    ctl.fetch_stop[g] <= ctl.hold[g];
                    ctl.irq_mask[g] <= ctl.hold[g];
                end
            end
        end
    endgenerate
endmodule // vp_target_gate

/* include/vp_ctrl_if.sv */
`timescale 1ns/1ps
// Per-target hold controls between the sequencer and the target gate
interface vp_ctrl_if;
    import vp_disable_pkg::*;
    logic [NUM_VP-1:0] hold;
    logic [NUM_VP-1:0] fetch_stop;
    logic [NUM_VP-1:0] irq_mask;
    modport seq (output hold, input fetch_stop, input irq_mask);
    modport gate (input hold, output fetch_stop, output irq_mask);
endinterface

/* include/vp_disable_pkg.sv */
package vp_disable_pkg;
    // ==========================================
    // Core geometry
    localparam int NUM_VP = 4;
    localparam int VP_ID_W = 2;
    localparam int DATA_W = 32;
    localparam int DEST_W = 5;

    // ==========================================
    // Instruction encoding
    localparam logic [5:0] MAJOR_GROUP_A = 6'h00;
    localparam logic [4:0] RSVD_FIELD_ZERO = 5'h00;
    localparam logic [9:0] DISABLE_MINOR = 10'h065;
    localparam logic [9:0] ENABLE_MINOR = 10'h165;
    localparam logic [5:0] MINOR_GROUP = 6'h3C;
    localparam int MAJOR_HI = 31;
    localparam int MAJOR_LO = 26;
    localparam int RSVD_HI = 25;
    localparam int RSVD_LO = 21;
    localparam int DEST_HI = 20;
    localparam int DEST_LO = 16;
    localparam int MINOR_HI = 15;
    localparam int MINOR_LO = 6;
    localparam int POOL_HI = 5;
    localparam int POOL_LO = 0;

    // ==========================================
    // Thread control register layout
    localparam int DISABLED_BIT = 0;
    localparam logic [DATA_W-1:0] THREAD_CTRL_RESET = 32'h0000_0000;

    // ==========================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DRAIN = 3'b001,
        ST_WRITEBACK = 3'b010,
        ST_ENABLE = 3'b011
    } seq_state_e;
endpackage

/* testbench/virtual_processor_disable_ctrl_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module virtual_processor_disable_ctrl_tb
    import vp_disable_pkg::*;
;
    logic clk_sys, reset, insn_valid, insn_oldest, cop_access_ok, multithread_present_flag;
    logic [DATA_W-1:0] insn;
    logic [VP_ID_W-1:0] issuer_id;
    logic [NUM_VP-1:0] outstanding, prefetch_busy, store_pending, ext_fetch_enable;
    logic insn_retire, insn_stall, cop_unusable, gpr_we, threads_disabled_flag;
    logic [DEST_W-1:0] gpr_waddr, wa_seen;
    logic [DATA_W-1:0] gpr_wdata, wd_seen;
    logic [NUM_VP-1:0] fetch_allow, irq_block, prefetch_kill, barrier_req, others;
    logic [3:0] delay;
    logic [7:0] rnd;
    logic [4:0] dst;
    logic m_flag, we_seen, prev_flag;
    int n_fail = 0;
    int tests_run = 0;

    virtual_processor_disable_ctrl DUT (.clk_sys(clk_sys), .reset(reset), .insn_valid(insn_valid), .insn(insn),
        .insn_oldest(insn_oldest), .issuer_id(issuer_id), .cop_access_ok(cop_access_ok),
        .multithread_present_flag(multithread_present_flag), .outstanding(outstanding),
        .prefetch_busy(prefetch_busy), .store_pending(store_pending), .ext_fetch_enable(ext_fetch_enable),
        .insn_retire(insn_retire), .insn_stall(insn_stall), .cop_unusable(cop_unusable), .gpr_we(gpr_we),
        .gpr_waddr(gpr_waddr), .gpr_wdata(gpr_wdata), .fetch_allow(fetch_allow), .irq_block(irq_block),
        .prefetch_kill(prefetch_kill), .barrier_req(barrier_req), .threads_disabled_flag(threads_disabled_flag));
    vp_partner far_side (.clk_sys(clk_sys), .reset(reset), .delay(delay), .fetch_allow(fetch_allow),
        .prefetch_kill(prefetch_kill), .barrier_req(barrier_req), .outstanding(outstanding),
        .prefetch_busy(prefetch_busy), .store_pending(store_pending));

    // ==========================================
    // Clock, helpers and verdict
    always #50 clk_sys = ~clk_sys;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [31:0] enc(input logic [9:0] minor, input logic [4:0] d);
        return {MAJOR_GROUP_A, RSVD_FIELD_ZERO, d, minor, MINOR_GROUP};
    endfunction

    task automatic close_out();
        if (n_fail == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Others must be idle and stopped when the flag rises
    always @(negedge clk_sys) begin
        if (!reset && threads_disabled_flag === 1'b1 && prev_flag !== 1'b1) begin
            `CHK("drained", 4'h0, (outstanding | prefetch_busy | store_pending) & others)
            `CHK("stopped", 4'h0, fetch_allow & others)
        end
        prev_flag = threads_disabled_flag;
    end

    // Presents one instruction, waits for its answer, then drops it
    task automatic run(input logic [31:0] w, input logic [1:0] who);
        int n, kind, ek;
        logic act, dis, hit;
        kind = 0;
        we_seen = 1'b0;
        others = ~(4'h1 << who);
        insn <= w;
        issuer_id <= who;
        insn_valid <= 1'b1;
        // Controls set by the caller at this edge have settled here
        @(negedge clk_sys);
        hit = w[31:26] == MAJOR_GROUP_A && w[25:21] == RSVD_FIELD_ZERO && w[5:0] == MINOR_GROUP
            && (w[15:6] == DISABLE_MINOR || w[15:6] == ENABLE_MINOR);
        dis = w[15:6] == DISABLE_MINOR;
        ek = (!hit || !insn_oldest) ? 0 : (cop_access_ok ? 1 : 2);
        act = ek == 1 && multithread_present_flag && (!dis || !m_flag);
        for (n = 0; n < 40 && kind == 0; n++) begin
            @(negedge clk_sys);
            if (gpr_we === 1'b1) begin
                we_seen = 1'b1;
                wa_seen = gpr_waddr;
                wd_seen = gpr_wdata;
            end
            if (insn_retire === 1'b1) kind = 1;
            else if (cop_unusable === 1'b1) kind = 2;
        end
        `CHK("answer", ek, kind)
        `CHK("gpr_we", act && dis && w[20:16] != 5'h00, we_seen)
        if (we_seen) begin
            `CHK("gpr_waddr", w[20:16], wa_seen)
            `CHK("gpr_wdata", THREAD_CTRL_RESET, wd_seen)
        end
        if (act) m_flag = dis;
        `CHK("flag", m_flag, threads_disabled_flag)
        @(posedge clk_sys);
        insn_valid <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Fetch and interrupt masks once the enable sync has settled
    task automatic check_vps();
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("fetch_allow", ext_fetch_enable & (m_flag ? ~others : 4'hF), fetch_allow)
        `CHK("irq_block", m_flag ? others : 4'h0, irq_block)
        @(posedge clk_sys);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        insn_valid = 1'b0;
        insn = '0;
        insn_oldest = 1'b1;
        issuer_id = '0;
        cop_access_ok = 1'b1;
        multithread_present_flag = 1'b1;
        ext_fetch_enable = 4'hF;
        delay = 4'h0;
        rnd = 8'h2C;
        m_flag = 1'b0;
        others = 4'hE;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        check_vps();
        for (int r = 0; r < 8; r++) begin
            rnd = lfsr(rnd);
            dst = (r == 0) ? 5'h00 : rnd[4:0];
            delay <= rnd[7:4];
            repeat (3) @(posedge clk_sys);
            run(enc(DISABLE_MINOR, dst), 2'(r));
            check_vps();
            ext_fetch_enable <= 4'h0;
            repeat (4) @(posedge clk_sys);
            ext_fetch_enable <= 4'hF;
            check_vps();
            run(enc(DISABLE_MINOR, rnd[6:2]), 2'(r));
            ext_fetch_enable <= 4'hF & ~(4'h1 << 2'(r + 1));
            run(enc(ENABLE_MINOR, 5'h00), 2'(r));
            check_vps();
            ext_fetch_enable <= 4'hF;
        end
        insn_oldest <= 1'b0;
        run(enc(DISABLE_MINOR, 5'h03), 2'h1);
        insn_oldest <= 1'b1;
        cop_access_ok <= 1'b0;
        run(enc(DISABLE_MINOR, 5'h03), 2'h1);
        cop_access_ok <= 1'b1;
        multithread_present_flag <= 1'b0;
        run(enc(DISABLE_MINOR, 5'h03), 2'h1);
        multithread_present_flag <= 1'b1;
        run(enc(DISABLE_MINOR, 5'h03) ^ 32'h0020_0000, 2'h1);
        run(enc(DISABLE_MINOR, 5'h03) ^ 32'h0000_0001, 2'h1);
        run(enc(DISABLE_MINOR, 5'h03) ^ 32'h0000_0040, 2'h1);
        check_vps();
        close_out();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(5000 * 100);
        n_fail++;
        close_out();
    end
endmodule // virtual_processor_disable_ctrl_tb

/* testbench/vp_partner.sv */
`timescale 1ns/1ps
// ==========================================
// Far-side model of the other processors
module vp_partner
    import vp_disable_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] delay,
    input wire logic [NUM_VP-1:0] fetch_allow,
    input wire logic [NUM_VP-1:0] prefetch_kill,
    input wire logic [NUM_VP-1:0] barrier_req,
    output logic [NUM_VP-1:0] outstanding,
    output logic [NUM_VP-1:0] prefetch_busy,
    output logic [NUM_VP-1:0] store_pending
);
    logic [3:0] cnt [NUM_VP];

    // Busy while fetching; work drains a delay after fetch stops
    always_ff @(posedge clk_sys or posedge reset) begin
        for (int i = 0; i < NUM_VP; i++) begin
            if (reset) begin
                cnt[i] <= 4'h0;
                outstanding[i] <= 1'b0;
                prefetch_busy[i] <= 1'b0;
                store_pending[i] <= 1'b0;
            end else if (fetch_allow[i]) begin
                cnt[i] <= delay;
                outstanding[i] <= 1'b1;
                prefetch_busy[i] <= 1'b1;
                store_pending[i] <= 1'b1;
            end else begin
                if (cnt[i] != 4'h0) cnt[i] <= cnt[i] - 4'h1;
                outstanding[i] <= (cnt[i] > 4'h1);
                // Walks and ordering only end when the core asks
                prefetch_busy[i] <= prefetch_busy[i] & ~prefetch_kill[i];
                store_pending[i] <= store_pending[i] & ~barrier_req[i];
            end
        end
    end
endmodule // vp_partner
